// *** dv/mode_sup_tb.sv ***
// Self-checking bench for the mode selector error supervisor
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) \
	begin \
		comparisons++; \
		if ((got) !== (exp)) \
		begin \
			failures++; \
			$display("ERROR %0t: got %0h expected %0h", $time, got, exp); \
		end \
	end
module mode_sup_tb;
	logic ref_clk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic activate_i = 1'b0;
	logic ce = 1'b1;
	logic [7:0] want = 8'h00;
	logic press = 1'b0;
	logic [7:0] sel;
	logic rst_pin;
	logic ready_o, error_o, any_o, pready_o, pslverr_o;
	logic [7:0] sel_out;
	logic [15:0] code;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata_o, rd;
	logic err;
	int failures = 0;
	int comparisons = 0;

	always #10 ref_clk_i = ~ref_clk_i;

	mode_sup u_mode_sup (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
		.ce_i(ce), .activate_i(activate_i), .mode_select_in_i(sel),
		.err_reset_i(rst_pin), .ready_o(ready_o), .error_o(error_o),
		.any_selection_active_o(any_o), .mode_selected_out_o(sel_out),
		.diagnostic_code_o(code), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
		.pready_o(pready_o), .prdata_o(prdata_o), .pslverr_o(pslverr_o));

	sel_switch_model u_sel_switch_model (.ref_clk_i(ref_clk_i),
		.want_i(want), .press_i(press), .mode_select_o(sel),
		.err_reset_o(rst_pin));

	////////////////////////////////////////////////////////////////////////
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk_i);
	endtask

	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] wd);
		@(posedge ref_clk_i);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge ref_clk_i);
		penable <= 1'b1;
		// No cycle count: only the watchdog ends a stuck wait
		do
		begin
			@(posedge ref_clk_i);
		end while (pready_o !== 1'b1);
		rd = prdata_o;
		err = pslverr_o;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Bounded wait, then one comparison on the code
	task automatic wait_code(input logic [15:0] exp, input int lim);
		int n;
		n = 0;
		while (code !== exp && n < lim)
		begin
			@(posedge ref_clk_i);
			n++;
		end
		`CHK(code, exp)
	endtask

	// Ready, error, both selection outputs low, code
	task automatic chk_out(input logic rdy, input logic e,
		input logic [15:0] c);
		`CHK(({ready_o, error_o, any_o, sel_out, code}),
			({rdy, e, 9'h000, c}))
	endtask

	task automatic end_sim();
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	task automatic t_start();
		chk_out(1'b0, 1'b0, 16'h0000);
		// Switch set first: the one-cycle reset limit would trip open
		want <= 8'h01;
		cyc(6);
		activate_i <= 1'b1;
		wait_code(16'h8005, 10);
		chk_out(1'b1, 1'b0, 16'h8005);
	endtask

	task automatic t_regs();
		apb(1'b1, 8'h00, 32'h0000_0014);
		apb(1'b0, 8'h00, 32'h0000_0000);
		`CHK(({err, rd}), 33'h0_0000_0014)
		apb(1'b1, 8'h04, 32'hFFFF_FFFF);
		apb(1'b0, 8'h04, 32'h0000_0000);
		`CHK(({err, rd[29:0]}), 31'h0201_8005)
		apb(1'b0, 8'h08, 32'h0000_0000);
		`CHK(({err, rd}), 33'h1_0000_0000)
	endtask

	// Enable low: no timeout although the switch stays open
	task automatic t_hold();
		ce <= 1'b0;
		want <= 8'h00;
		cyc(30);
		`CHK(code, 16'h8005)
		want <= 8'h01;
		cyc(6);
		ce <= 1'b1;
		cyc(4);
		chk_out(1'b1, 1'b0, 16'h8005);
	endtask

	task automatic t_short(input logic [15:0] c);
		want <= 8'h81;
		wait_code(16'hC001, 8);
		wait_code(c, 2);
		chk_out(1'b1, 1'b1, c);
		want <= 8'h01;
		press <= 1'b0;
		cyc(6);
		press <= 1'b1;
		wait_code(16'h8005, 6);
	endtask

	task automatic t_open(input logic [15:0] c);
		want <= 8'h00;
		cyc(18);
		`CHK(code, 16'h8005)
		wait_code(16'hC002, 10);
		wait_code(c, 2);
		chk_out(1'b1, 1'b1, c);
		want <= 8'h01;
		press <= 1'b0;
		cyc(6);
		press <= 1'b1;
		wait_code(16'h8005, 6);
	endtask

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		cyc(2);
		nrst_i <= 1'b1;
		t_start();
		t_regs();
		t_hold();
		press <= 1'b0;
		cyc(4);
		t_short(16'hC001);
		press <= 1'b0;
		cyc(4);
		t_open(16'hC002);
		t_short(16'hC003);
		t_open(16'hC004);
		t_short(16'hC003);
		activate_i <= 1'b0;
		wait_code(16'h0000, 6);
		chk_out(1'b0, 1'b0, 16'h0000);
		end_sim();
	end

	// Whole run is a few hundred cycles
	initial
	begin
		cyc(5000);
		failures++;
		end_sim();
	end
endmodule
`default_nettype wire

// *** dv/sel_switch_model.sv ***
// Behavioural selector switch and operator reset button
`timescale 1ns/1ps
`default_nettype none
module sel_switch_model #(
	parameter int unsigned GAP = 2
) (
	// Clock
	input wire logic ref_clk_i,
	// Commands from the bench
	input wire logic [7:0] want_i,
	input wire logic press_i,
	// Pins
	output logic [7:0] mode_select_o,
	output logic err_reset_o
);
	int unsigned gap_cnt = 0;
	initial mode_select_o = 8'h00;
	initial err_reset_o = 1'b0;
	// Break before make, so every move passes through all-open
	always @(posedge ref_clk_i)
	begin
		err_reset_o <= press_i;
		if (want_i == mode_select_o)
			gap_cnt <= 0;
		else if (mode_select_o != 8'h00)
			mode_select_o <= 8'h00;
		else if (gap_cnt < GAP && want_i != 8'h00)
			gap_cnt <= gap_cnt + 1;
		else
			mode_select_o <= want_i;
	end
endmodule
`default_nettype wire

// *** rtl/mode_sup.sv ***
// Mode selector error supervisor with APB status and timeout registers
`timescale 1ns/1ps
`default_nettype none

module mode_sup (
	// Clock, reset, enable
	input wire logic ref_clk_i,
	input wire logic nrst_i,
	input wire logic ce_i,
	// Pins
	input wire logic activate_i,
	input wire logic [7:0] mode_select_in_i,
	input wire logic err_reset_i,
	// Supervisor outputs
	output logic ready_o,
	output logic error_o,
	output logic any_selection_active_o,
	output logic [7:0] mode_selected_out_o,
	output logic [15:0] diagnostic_code_o,
	// APB slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic pready_o,
	output logic [31:0] prdata_o,
	output logic pslverr_o
);
	////////////////////////////////////////////////////////////////////////
	logic [mode_sup_pkg::SYNC_W-1:0] pins_s;
	logic act_s;
	logic rst_s;
	logic [7:0] sel_s;

	pin_sync #(
		.W(mode_sup_pkg::SYNC_W)
	) u_sync (
		.ref_clk_i(ref_clk_i),
		.nrst_i(nrst_i),
		.ce_i(ce_i),
		.d_i({activate_i, err_reset_i, mode_select_in_i}),
		.q_o(pins_s)
	);

	assign act_s = pins_s[9];
	assign rst_s = pins_s[8];
	assign sel_s = pins_s[7:0];

	function automatic logic [3:0] ones(input logic [7:0] v);
		logic [3:0] n;
		n = 4'h0;
		for (int i = 0; i < 8; i++)
			n = n + {3'h0, v[i]};
		return n;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Supervisor state
	mode_sup_pkg::sup_state_t state_ff;
	mode_sup_pkg::sup_state_t nxt_state;
	logic [31:0] cnt_ff;
	logic [31:0] nxt_cnt;
	logic [31:0] limit_ff;
	logic [7:0] sel_prev_ff;
	logic rst_prev_ff;
	logic entry_ff;
	logic nxt_entry;
	logic rst_rise;
	logic sel_fall;
	logic sel_none;
	logic sel_multi;
	logic is_err;

	assign rst_rise = rst_s & ~rst_prev_ff;
	assign sel_fall = |(sel_prev_ff & ~sel_s);
	assign sel_none = (sel_s == 8'h00);
	assign sel_multi = (ones(sel_s) > 4'h1);
	assign is_err = (state_ff != mode_sup_pkg::ST_IDLE) &&
		(state_ff != mode_sup_pkg::ST_AWAIT);

	always_comb
	begin
		nxt_state = state_ff;
		nxt_cnt = cnt_ff;
		if (ce_i)
		begin
			case (state_ff)
				mode_sup_pkg::ST_IDLE:
				begin
					nxt_cnt = 32'h0000_0000;
					if (act_s)
						nxt_state = mode_sup_pkg::ST_AWAIT;
				end
				mode_sup_pkg::ST_AWAIT:
				begin
					if (sel_multi)
						nxt_state = mode_sup_pkg::ST_ERR_SHORT;
					else if (sel_fall || !sel_none)
						nxt_cnt = 32'h0000_0000;
					else if (cnt_ff + 32'h0000_0001 >= limit_ff)
						nxt_state = mode_sup_pkg::ST_ERR_OPEN;
					else
						nxt_cnt = cnt_ff + 32'h0000_0001;
				end
				mode_sup_pkg::ST_ERR_SHORT:
				begin
					if (entry_ff && rst_s)
						nxt_state = mode_sup_pkg::ST_ERR_RST1;
					else if (rst_rise)
						nxt_state = mode_sup_pkg::ST_AWAIT;
				end
				mode_sup_pkg::ST_ERR_OPEN:
				begin
					if (entry_ff && rst_s)
						nxt_state = mode_sup_pkg::ST_ERR_RST2;
					else if (rst_rise)
						nxt_state = mode_sup_pkg::ST_AWAIT;
				end
				mode_sup_pkg::ST_ERR_RST1,
				mode_sup_pkg::ST_ERR_RST2:
				begin
					if (rst_rise)
						nxt_state = mode_sup_pkg::ST_AWAIT;
				end
				default:
					nxt_state = mode_sup_pkg::ST_IDLE;
			endcase
			if (nxt_state != state_ff)
				nxt_cnt = 32'h0000_0000;
			if (!act_s)
			begin
				nxt_state = mode_sup_pkg::ST_IDLE;
				nxt_cnt = 32'h0000_0000;
			end
		end
		nxt_entry = ce_i ? (nxt_state != state_ff) : entry_ff;
	end

	// Outputs decoded from next state so they align with state_ff
	logic nxt_ready;
	logic nxt_error;
	logic [15:0] nxt_diag;

	always_comb
	begin
		nxt_ready = 1'b1;
		nxt_error = 1'b1;
		case (nxt_state)
			mode_sup_pkg::ST_IDLE:
			begin
				nxt_ready = 1'b0;
				nxt_error = 1'b0;
				nxt_diag = mode_sup_pkg::DIAG_IDLE;
			end
			mode_sup_pkg::ST_AWAIT:
			begin
				nxt_error = 1'b0;
				nxt_diag = mode_sup_pkg::DIAG_AWAIT;
			end
			mode_sup_pkg::ST_ERR_SHORT:
				nxt_diag = mode_sup_pkg::DIAG_SHORT;
			mode_sup_pkg::ST_ERR_OPEN:
				nxt_diag = mode_sup_pkg::DIAG_OPEN;
			mode_sup_pkg::ST_ERR_RST1:
				nxt_diag = mode_sup_pkg::DIAG_RST1;
			mode_sup_pkg::ST_ERR_RST2:
				nxt_diag = mode_sup_pkg::DIAG_RST2;
			default:
			begin
				nxt_ready = 1'b0;
				nxt_error = 1'b0;
				nxt_diag = mode_sup_pkg::DIAG_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			state_ff <= mode_sup_pkg::ST_IDLE;
			cnt_ff <= 32'h0000_0000;
			sel_prev_ff <= 8'h00;
			rst_prev_ff <= 1'b0;
			entry_ff <= 1'b0;
			ready_o <= 1'b0;
			error_o <= 1'b0;
			diagnostic_code_o <= mode_sup_pkg::DIAG_IDLE;
			any_selection_active_o <= 1'b0;
			mode_selected_out_o <= 8'h00;
		end
		else if (ce_i)
		begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
			sel_prev_ff <= sel_s;
			rst_prev_ff <= rst_s;
			entry_ff <= nxt_entry;
			ready_o <= nxt_ready;
			error_o <= nxt_error;
			diagnostic_code_o <= nxt_diag;
			// Selection itself is handled elsewhere; held safe here
			any_selection_active_o <= 1'b0;
			mode_selected_out_o <= 8'h00;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// APB slave, one wait state so read data comes from a flip-flop
	logic [31:0] nxt_limit;
	logic nxt_pready;
	logic [31:0] nxt_prdata;
	logic nxt_pslverr;
	logic addr_ok;
	logic apb_done;

	assign addr_ok = (paddr_i == mode_sup_pkg::OFS_TIMEOUT) ||
		(paddr_i == mode_sup_pkg::OFS_STATUS);
	assign apb_done = psel_i & penable_i & pready_o;

	always_comb
	begin
		nxt_limit = limit_ff;
		nxt_pready = 1'b0;
		nxt_prdata = prdata_o;
		nxt_pslverr = 1'b0;
		if (apb_done && pwrite_i && paddr_i == mode_sup_pkg::OFS_TIMEOUT)
			nxt_limit = pwdata_i;
		if (psel_i && penable_i && !pready_o)
		begin
			nxt_pready = 1'b1;
			nxt_pslverr = !addr_ok;
			nxt_prdata = 32'h0000_0000;
			if (paddr_i == mode_sup_pkg::OFS_TIMEOUT)
				nxt_prdata = limit_ff;
			else if (paddr_i == mode_sup_pkg::OFS_STATUS)
			begin
				nxt_prdata[mode_sup_pkg::ST_DIAG_LSB +: 16] =
					diagnostic_code_o;
				nxt_prdata[mode_sup_pkg::ST_READY_BIT] = ready_o;
				nxt_prdata[mode_sup_pkg::ST_ERROR_BIT] = error_o;
				nxt_prdata[mode_sup_pkg::ST_STATE_LSB +: 6] = state_ff;
			end
		end
	end

	always_ff @(posedge ref_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			limit_ff <= mode_sup_pkg::TIMEOUT_RST;
			pready_o <= 1'b0;
			prdata_o <= 32'h0000_0000;
			pslverr_o <= 1'b0;
		end
		else if (ce_i)
		begin
			limit_ff <= nxt_limit;
			pready_o <= nxt_pready;
			prdata_o <= nxt_prdata;
			pslverr_o <= nxt_pslverr;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	a_idle_priority: assert property (@(posedge ref_clk_i)
		disable iff (!nrst_i)
		(ce_i && !act_s) |=> (state_ff == mode_sup_pkg::ST_IDLE &&
		diagnostic_code_o == 16'h0000 && !ready_o))
		else $error("activate low did not force idle");

	a_short_detect: assert property (@(posedge ref_clk_i)
		disable iff (!nrst_i)
		(ce_i && act_s && state_ff == mode_sup_pkg::ST_AWAIT &&
		ones(sel_s) >= 4'h2) |=> (diagnostic_code_o == 16'hC001))
		else $error("short circuit not flagged at once");

	a_open_detect: assert property (@(posedge ref_clk_i)
		disable iff (!nrst_i)
		(ce_i && act_s && state_ff == mode_sup_pkg::ST_AWAIT &&
		sel_s == 8'h00 && !sel_fall && cnt_ff + 1 >= limit_ff)
		|=> (diagnostic_code_o == 16'hC002 && error_o))
		else $error("open circuit not flagged at timeout");

	a_timer_restart: assert property (@(posedge ref_clk_i)
		disable iff (!nrst_i)
		(ce_i && act_s && state_ff == mode_sup_pkg::ST_AWAIT &&
		sel_fall) |=> (cnt_ff == 32'h0000_0000))
		else $error("timer not restarted on falling select");

	a_reset_err1: assert property (@(posedge ref_clk_i)
		disable iff (!nrst_i)
		(ce_i && act_s && state_ff == mode_sup_pkg::ST_ERR_SHORT &&
		entry_ff && rst_s) |=> (diagnostic_code_o == 16'hC003))
		else $error("reset held at short entry not flagged");

	a_reset_err2: assert property (@(posedge ref_clk_i)
		disable iff (!nrst_i)
		(ce_i && act_s && state_ff == mode_sup_pkg::ST_ERR_OPEN &&
		entry_ff && rst_s) |=> (diagnostic_code_o == 16'hC004))
		else $error("reset held at open entry not flagged");

	a_err_outputs: assert property (@(posedge ref_clk_i)
		disable iff (!nrst_i)
		is_err |-> (ready_o && error_o && !any_selection_active_o &&
		mode_selected_out_o == 8'h00 && diagnostic_code_o[15:12] == 4'hC))
		else $error("error state outputs not safe");

	a_error_exit: assert property (@(posedge ref_clk_i)
		disable iff (!nrst_i)
		(ce_i && act_s && is_err && rst_rise && !(entry_ff && rst_s))
		|=> (diagnostic_code_o == 16'h8005 && !error_o && ready_o))
		else $error("reset edge did not clear error");

	a_await_outputs: assert property (@(posedge ref_clk_i)
		disable iff (!nrst_i)
		(ce_i && act_s && $past(state_ff) == mode_sup_pkg::ST_IDLE &&
		state_ff == mode_sup_pkg::ST_IDLE) |=> (diagnostic_code_o ==
		16'h8005 && ready_o && !error_o && !any_selection_active_o))
		else $error("activation did not reach awaiting");

	c_short: cover property (@(posedge ref_clk_i)
		state_ff == mode_sup_pkg::ST_ERR_SHORT);
	c_open: cover property (@(posedge ref_clk_i)
		state_ff == mode_sup_pkg::ST_ERR_OPEN);
	c_rst2: cover property (@(posedge ref_clk_i)
		state_ff == mode_sup_pkg::ST_ERR_RST2);
	c_recover: cover property (@(posedge ref_clk_i)
		is_err ##1 state_ff == mode_sup_pkg::ST_AWAIT);
endmodule
`default_nettype wire

// *** rtl/mode_sup_pkg.sv ***
// Constants and types for the mode selector error supervisor
package mode_sup_pkg;

	// Clock and monitor time
	localparam int unsigned CLK_HZ = 50_000_000;
	localparam int unsigned NO_SEL_TIMEOUT_MS = 0;
	localparam int unsigned NO_SEL_TIMEOUT_RAW =
		(CLK_HZ / 1000) * NO_SEL_TIMEOUT_MS;
	localparam int unsigned NO_SEL_TIMEOUT_CYC =
		(NO_SEL_TIMEOUT_RAW < 1) ? 1 : NO_SEL_TIMEOUT_RAW;

	// Widths
	localparam int unsigned MODE_W = 8;
	localparam int unsigned CNT_W = 32;
	localparam int unsigned DIAG_W = 16;
	localparam int unsigned SYNC_W = MODE_W + 2;

	// Diagnostic codes
	localparam logic [15:0] DIAG_IDLE = 16'h0000;
	localparam logic [15:0] DIAG_AWAIT = 16'h8005;
	localparam logic [15:0] DIAG_SHORT = 16'hC001;
	localparam logic [15:0] DIAG_OPEN = 16'hC002;
	localparam logic [15:0] DIAG_RST1 = 16'hC003;
	localparam logic [15:0] DIAG_RST2 = 16'hC004;

	// Register map (byte addresses)
	localparam logic [7:0] OFS_TIMEOUT = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [31:0] TIMEOUT_RST = 32'(NO_SEL_TIMEOUT_CYC);

	// Status register fields
	localparam int unsigned ST_DIAG_LSB = 0;
	localparam int unsigned ST_READY_BIT = 16;
	localparam int unsigned ST_ERROR_BIT = 17;
	localparam int unsigned ST_STATE_LSB = 24;

	typedef enum logic [5:0] {
		ST_IDLE = 6'b00_0001,
		ST_AWAIT = 6'b00_0010,
		ST_ERR_SHORT = 6'b00_0100,
		ST_ERR_OPEN = 6'b00_1000,
		ST_ERR_RST1 = 6'b01_0000,
		ST_ERR_RST2 = 6'b10_0000
	} sup_state_t;

endpackage

// *** rtl/pin_sync.sv ***
// Two-stage synchroniser for a group of pin inputs
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
	parameter int unsigned W = 1
) (
	// Clock, reset, enable
	input wire logic ref_clk_i,
	input wire logic nrst_i,
	input wire logic ce_i,
	// Data
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	logic [W-1:0] meta_ff;
	logic [W-1:0] sync_ff;
	logic [W-1:0] nxt_meta;
	logic [W-1:0] nxt_sync;

	always_comb
	begin
		nxt_meta = ce_i ? d_i : meta_ff;
		nxt_sync = ce_i ? meta_ff : sync_ff;
	end

	always_ff @(posedge ref_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			meta_ff <= '0;
			sync_ff <= '0;
		end
		else
		begin
			meta_ff <= nxt_meta;
			sync_ff <= nxt_sync;
		end
	end

	assign q_o = sync_ff;
endmodule
`default_nettype wire
